// File: bwca_pkg.sv
// bwca_pkg: constants and carrier types for the ble / wlan coexistence arbiter.
// assumes a single 125 MHz device clock; all users write bwca_pkg::name.
package bwca_pkg;

	// device clock rate
	localparam int unsigned CLK_MHZ = 125;

	// length of one start-up calibration slot, in microseconds
	localparam int unsigned CAL_TIME_US = 20;
	// the same slot in device clock cycles (whole microseconds, exact)
	localparam int unsigned CAL_CYC = CAL_TIME_US * CLK_MHZ;

	// calibration attempts before start-up gives up
	localparam int unsigned CAL_TRIES = 4;

	// synchroniser depth for every pin that enters the block
	localparam int unsigned SYNC_STAGES = 2;

	// cycles after reset release before the configuration strap is trusted
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// reset values of the controls
	localparam logic COEX_ON_RST = 1'b0;
	localparam logic GRANT_RST = 1'b0;

	// failure cause codes
	localparam logic [1:0] FAIL_NONE = 2'h0;
	localparam logic [1:0] FAIL_PAD = 2'h1;
	localparam logic [1:0] FAIL_CAL = 2'h2;

	// start-up and run states, one-hot
	typedef enum logic [3:0] {
		BWCA_ST_OFF = 4'h1,
		BWCA_ST_CAL = 4'h2,
		BWCA_ST_RUN = 4'h4,
		BWCA_ST_FAIL = 4'h8
	} bwca_state_t;

	// wlan-side view of the configuration
	typedef struct packed {
		logic shared_ant; // one antenna, rf switch fitted
		logic band_5g; // radio currently on the 5 ghz band
		logic pad_claimed; // a coexistence pad was muxed elsewhere
	} bwca_cfg_t;

	// status returned to the wlan core
	typedef struct packed {
		logic running; // start-up finished, arbitration live
		logic failed; // start-up failed
		logic [1:0] cause; // failure cause code
		logic ble_active; // synchronised ble request seen
		logic coex_on; // arbitration enabled
		logic [2:0] tries; // calibration attempts used
	} bwca_status_t;

endpackage : bwca_pkg

// File: bwca_sync.sv
// bwca_sync: flip-flop chain bringing asynchronous pins into the device clock.
// assumes pins are pulled low when their driver is off, so reset value is zero.
`timescale 1ns/1ps
module bwca_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = bwca_pkg::SYNC_STAGES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);

	// chain of stages; only the next stage reads each one
	logic [WIDTH-1:0] stage_q [STAGES];

	// refuse a chain too short to settle metastability
	initial begin
		if (STAGES < 2 || WIDTH < 1) begin
			$error("bwca_sync: needs at least two stages and one bit");
		end
	end

	// shift the pin through the chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
		end else begin
			stage_q[0] <= pin_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign sync_out = stage_q[STAGES-1];

endmodule : bwca_sync

// File: bwca_arbiter.sv
// bwca_arbiter: coexistence arbiter inside the wlan device.
// assumes ble_req and cfg_strap are raw pins with pull-downs; all other inputs
// come from wlan logic on clk.
//
// Function
// (RL1) ble activity takes precedence over wlan air time
// (RL2) ble holds request high through tx and rx
// (RL3) hold pending 2.4 ghz tx while request high
// (RL4) second line drives shared antenna rf switch
// (RL5) 5 ghz operation ignores the ble request
// (RL6) coexistence enabled by software or strap
// (RL7) pulled-low request reads inactive, nothing blocked
// (RL8) ble stays idle during normal start-up calibration
// (RL9) retry interrupted calibration, fail if never granted
// (RL10) ble raises request over 100 us early
// (RL11) dual antenna: no new tx, rx still allowed
// (RL12) claimed coexistence pad makes start-up fail
// (RL13) request passes two-stage synchroniser before use
`timescale 1ns/1ps
module bwca_arbiter #(
	parameter int unsigned CAL_CYCLES = bwca_pkg::CAL_CYC,
	parameter int unsigned CAL_TRIES = bwca_pkg::CAL_TRIES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ble_req,
	input wire logic cfg_strap,
	input wire logic sw_coex_set,
	input wire logic sw_coex_clr,
	input wire bwca_pkg::bwca_cfg_t cfg,
	input wire logic init_start,
	input wire logic tx_pending,
	output logic tx_grant,
	output logic rx_enable,
	output logic ant_to_ble,
	output bwca_pkg::bwca_status_t status
);

	// widths sized from the parameters
	localparam int unsigned CW = $clog2(CAL_CYCLES + 1);
	localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
	localparam logic [2:0] TRY_MAX = 3'(CAL_TRIES);
	// grant level during reset, declared ahead of its first use
	localparam logic GRANT_RST_L = bwca_pkg::GRANT_RST;

	// refuse settings the counters cannot hold
	initial begin
		if (CAL_CYCLES < 1 || CAL_TRIES < 1 || CAL_TRIES > 7) begin
			$error("bwca_arbiter: calibration cycles or tries out of range");
		end
	end

	// synchronised pins
	logic ble_sync; // ble request in clk domain
	logic strap_sync; // configuration strap in clk domain

	// enable and strap capture
	logic coex_on_q;
	logic [1:0] strap_cnt_q; // settle count after reset release
	logic strap_done_q; // strap already applied

	// start-up sequencer
	bwca_pkg::bwca_state_t state_q;
	bwca_pkg::bwca_state_t state_d;
	logic [CW-1:0] cal_cnt_q; // cycles of clean calibration so far
	logic [2:0] tries_q; // calibration attempts started
	logic [1:0] cause_q;

	// registered outputs
	logic tx_grant_q;
	logic rx_enable_q;
	logic ant_to_ble_q;

	// arbitration terms
	logic ble_block; // ble currently owns 2.4 ghz air time
	logic cal_hit; // ble took air time during calibration

	// both pins through the chain; only the last stage is read here
	bwca_sync #(
		.WIDTH(2),
		.STAGES(bwca_pkg::SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.pin_in({cfg_strap, ble_req}),
		.sync_out({strap_sync, ble_sync})
	); // RL13

	// a floating-low pin is simply a low request: no special case needed,
	// an off or sleeping ble radio never blocks anything
	assign ble_block = coex_on_q && ble_sync && !cfg.band_5g; // RL1 RL5 RL6 RL7

	// calibration counts as disturbed whenever ble takes the air;
	// we rely on the ble side staying idle here, this only copes if not
	assign cal_hit = ble_block; // RL8 RL9

	// strap settle counter; strap value is caught only after release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == bwca_pkg::STRAP_WAIT) begin
				strap_done_q <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	// coexistence enable: strap gives the default, software overrides
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coex_on_q <= bwca_pkg::COEX_ON_RST;
		end else if (sw_coex_set) begin
			coex_on_q <= 1'b1; // RL6
		end else if (sw_coex_clr) begin
			coex_on_q <= 1'b0; // RL6
		end else if (!strap_done_q && strap_cnt_q == bwca_pkg::STRAP_WAIT) begin
			coex_on_q <= strap_sync; // RL6
		end
	end

	// start-up state transitions
	always_comb begin
		state_d = state_q;
		case (state_q)
			bwca_pkg::BWCA_ST_OFF: begin
				if (init_start) begin
					// pad stolen before start-up: refuse to come up
					if (cfg.pad_claimed) begin
						state_d = bwca_pkg::BWCA_ST_FAIL; // RL12
					end else begin
						state_d = bwca_pkg::BWCA_ST_CAL;
					end
				end
			end
			bwca_pkg::BWCA_ST_CAL: begin
				if (cal_hit && tries_q >= TRY_MAX) begin
					// never got a whole calibration slot
					state_d = bwca_pkg::BWCA_ST_FAIL; // RL9
				end else if (!cal_hit && cal_cnt_q == CAL_LAST) begin
					state_d = bwca_pkg::BWCA_ST_RUN;
				end
			end
			bwca_pkg::BWCA_ST_RUN: begin
				state_d = bwca_pkg::BWCA_ST_RUN;
			end
			bwca_pkg::BWCA_ST_FAIL: begin
				// a new start attempt is allowed once the pad is free
				if (init_start && !cfg.pad_claimed) begin
					state_d = bwca_pkg::BWCA_ST_CAL;
				end
			end
			default: begin
				state_d = bwca_pkg::BWCA_ST_OFF;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= bwca_pkg::BWCA_ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// calibration slot counter and attempt count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_cnt_q <= '0;
			tries_q <= 3'h0;
		end else if (state_q != bwca_pkg::BWCA_ST_CAL) begin
			cal_cnt_q <= '0;
			// first attempt counted as it begins
			if (state_d == bwca_pkg::BWCA_ST_CAL) begin
				tries_q <= 3'h1;
			end
		end else if (cal_hit) begin
			// slot spoiled: start again from zero
			cal_cnt_q <= '0; // RL9
			if (tries_q < TRY_MAX) begin
				tries_q <= tries_q + 3'h1; // RL9
			end
		end else if (cal_cnt_q != CAL_LAST) begin
			cal_cnt_q <= cal_cnt_q + CW'(1);
		end
	end

	// failure cause, held until the next attempt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cause_q <= bwca_pkg::FAIL_NONE;
		end else if (state_d == bwca_pkg::BWCA_ST_FAIL && state_q != bwca_pkg::BWCA_ST_FAIL) begin
			if (state_q == bwca_pkg::BWCA_ST_OFF) begin
				cause_q <= bwca_pkg::FAIL_PAD; // RL12
			end else begin
				cause_q <= bwca_pkg::FAIL_CAL; // RL9
			end
		end else if (state_d == bwca_pkg::BWCA_ST_CAL) begin
			cause_q <= bwca_pkg::FAIL_NONE;
		end
	end

	// transmit grant: held back while ble owns the air, released the
	// cycle after the synchronised request drops; 5 ghz never waits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_grant_q <= GRANT_RST_L;
		end else begin
			tx_grant_q <= (state_q == bwca_pkg::BWCA_ST_RUN) && tx_pending && !ble_block; // RL3 RL5 RL11
		end
	end

	// receive stays open in run, even while ble is active
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_enable_q <= 1'b0;
		end else begin
			rx_enable_q <= (state_q == bwca_pkg::BWCA_ST_RUN); // RL11
		end
	end

	// rf switch line: routes the shared antenna to ble while it is active;
	// idle low matches the external pull-down on this line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ant_to_ble_q <= 1'b0;
		end else begin
			ant_to_ble_q <= cfg.shared_ant && ble_block; // RL4 RL1
		end
	end

	// outputs straight from flops; status running and failed decoded from state_q
	assign tx_grant = tx_grant_q;
	assign rx_enable = rx_enable_q;
	assign ant_to_ble = ant_to_ble_q;
	assign status = '{
		running: (state_q == bwca_pkg::BWCA_ST_RUN),
		failed: (state_q == bwca_pkg::BWCA_ST_FAIL),
		cause: cause_q,
		ble_active: ble_sync,
		coex_on: coex_on_q,
		tries: tries_q
	};

endmodule : bwca_arbiter

// File: bwca_arbiter_asserts.sv
// bwca_arbiter_asserts: port-level checks on the coexistence arbiter.
// assumes ble_req changes just after clk edges and one clock domain.
`timescale 1ns/1ps
module bwca_arbiter_asserts #(
	parameter int unsigned CAL_CYCLES = bwca_pkg::CAL_CYC,
	parameter int unsigned CAL_TRIES = bwca_pkg::CAL_TRIES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ble_req,
	input wire logic init_start,
	input wire logic tx_pending,
	input wire bwca_pkg::bwca_cfg_t cfg,
	input wire logic tx_grant,
	input wire logic rx_enable,
	input wire logic ant_to_ble,
	input wire bwca_pkg::bwca_status_t status
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// blocking condition seen for whole sync path plus output flop
	sequence blk_s;
		ble_req && status.coex_on && !cfg.band_5g;
	endsequence
	AST_BLOCK: assert property (blk_s [*4] |-> !tx_grant) else $error("grant while ble active");
	AST_ANT: assert property ((ble_req && status.coex_on && !cfg.band_5g && cfg.shared_ant) [*4] |-> ant_to_ble) else $error("switch not to ble");
	// dual antenna: the switch line must never move towards ble
	AST_DUAL: assert property (!cfg.shared_ant [*2] |-> !ant_to_ble) else $error("switch moved without shared antenna");
	AST_GRANT: assert property ((status.running && tx_pending && !ble_req) [*4] |=> tx_grant) else $error("grant missing");
	AST_NOTRUN: assert property (!status.running |-> !tx_grant) else $error("grant before run");
	AST_5G: assert property (cfg.band_5g [*4] |-> !ant_to_ble) else $error("switch moved on 5g");
	AST_5G_TX: assert property ((status.running && tx_pending && cfg.band_5g) [*2] |=> tx_grant) else $error("5g tx held");
	AST_OFF: assert property (status.running && tx_pending && !status.coex_on |=> tx_grant) else $error("tx held while off");
	AST_RX: assert property (status.running [*2] |-> rx_enable) else $error("rx not allowed");
	// a one-cycle drop would mean the request skipped the synchroniser
	AST_SYNC: assert property ($rose(ble_req) && tx_grant && tx_pending ##1 tx_pending |=> tx_grant) else $error("request not synced");
	AST_PAD: assert property (init_start && cfg.pad_claimed && !status.running && !status.failed && status.tries == 3'h0
		|=> status.failed && status.cause == bwca_pkg::FAIL_PAD) else $error("pad claim not failed");
	AST_TRIES: assert property (status.tries <= CAL_TRIES && !(status.failed && status.running)) else $error("bad tries");
	COV_BLOCK: cover property (blk_s ##4 !tx_grant);
	COV_CALFAIL: cover property (status.failed && status.cause == bwca_pkg::FAIL_CAL);
	COV_RUN: cover property ($rose(status.running));
	COV_DUAL: cover property (status.ble_active && !cfg.shared_ant && !tx_grant && rx_enable);
endmodule : bwca_arbiter_asserts

bind bwca_arbiter bwca_arbiter_asserts #(.CAL_CYCLES(CAL_CYCLES), .CAL_TRIES(CAL_TRIES)) bwca_arbiter_asserts_inst (
	.clk(clk), .rst(rst), .ble_req(ble_req), .init_start(init_start), .tx_pending(tx_pending), .cfg(cfg),
	.tx_grant(tx_grant), .rx_enable(rx_enable), .ant_to_ble(ant_to_ble), .status(status));

// File: bwca_ble_model.sv
// bwca_ble_model: ble radio side, raises its request around radio activity.
// assumes act comes from the bench; off state reads as the pulled-low level.
`timescale 1ns/1ps
module bwca_ble_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic act,
	output logic ble_req
);
	// request wraps the whole activity; bench holds act long before air use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ble_req <= 1'b0;
		end else begin
			ble_req <= act;
		end
	end
endmodule : bwca_ble_model

// File: test_ble_wlan_coex_arbiter.sv
// test_ble_wlan_coex_arbiter: directed bench for the coexistence arbiter.
// assumes a shortened calibration slot of 8 cycles and default try count.
`timescale 1ns/1ps
module test_ble_wlan_coex_arbiter;
	logic clk = 1'b0, rst = 1'b1, act = 1'b0, cfg_strap = 1'b0, sw_coex_set = 1'b0, sw_coex_clr = 1'b0;
	logic init_start = 1'b0, tx_pending = 1'b0, ble_req, tx_grant, rx_enable, ant_to_ble;
	bwca_pkg::bwca_cfg_t cfg = '0;
	bwca_pkg::bwca_status_t status;
	int n_errors = 0, n_checks = 0;
	// 125 mhz device clock
	always #4 clk = ~clk;
	bwca_ble_model bwca_ble_model_inst (.clk(clk), .rst(rst), .act(act), .ble_req(ble_req));
	bwca_arbiter #(.CAL_CYCLES(8)) bwca_arbiter_inst (.clk(clk), .rst(rst), .ble_req(ble_req), .cfg_strap(cfg_strap),
		.sw_coex_set(sw_coex_set), .sw_coex_clr(sw_coex_clr), .cfg(cfg), .init_start(init_start),
		.tx_pending(tx_pending), .tx_grant(tx_grant), .rx_enable(rx_enable), .ant_to_ble(ant_to_ble), .status(status));
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task check(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(posedge clk);
	endtask : step
	// look lets the edge's updates land before sampling
	task look(input int n);
		step(n);
		#1;
	endtask : look
	// bounded wait on failed (sel=1) or running (sel=0)
	task wait_on(input logic sel);
		for (int i = 0; i < 200; i++) begin
			look(1);
			if ((sel ? status.failed : status.running) === 1'b1) return;
		end
		n_errors++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		wrap_up();
	endtask : wait_on
	task start;
		step(1);
		init_start <= 1'b1;
		step(1);
		init_start <= 1'b0;
	endtask : start
	task t_pad;
		cfg.pad_claimed <= 1'b1;
		start();
		wait_on(1'b1);
		check(status.cause, bwca_pkg::FAIL_PAD);
		check(status.running, 1'b0);
		$display("test pad done");
	endtask : t_pad
	task t_calfail;
		step(1);
		cfg.pad_claimed <= 1'b0;
		sw_coex_set <= 1'b1;
		act <= 1'b1;
		step(1);
		sw_coex_set <= 1'b0;
		step(4);
		start();
		wait_on(1'b1);
		check(status.cause, bwca_pkg::FAIL_CAL);
		check(status.tries, 3'(bwca_pkg::CAL_TRIES));
		$display("test cal fail done");
	endtask : t_calfail
	task t_calok;
		step(1);
		act <= 1'b0;
		step(4);
		start();
		wait_on(1'b0);
		look(1);
		check(rx_enable, 1'b1);
		check(status.failed, 1'b0);
		$display("test cal ok done");
	endtask : t_calok
	task t_block;
		step(1);
		cfg.shared_ant <= 1'b1;
		tx_pending <= 1'b1;
		look(1);
		check(tx_grant, 1'b1);
		step(1);
		act <= 1'b1;
		look(3);
		check(tx_grant, 1'b1);
		look(1);
		check({tx_grant, ant_to_ble, rx_enable, status.ble_active}, 4'h7);
		step(1);
		act <= 1'b0;
		look(3);
		check(tx_grant, 1'b0);
		look(1);
		check({tx_grant, ant_to_ble}, 2'h2);
		$display("test block done");
	endtask : t_block
	// dual antenna: tx held, switch left alone, rx stays open
	task t_dual;
		step(1);
		cfg.shared_ant <= 1'b0;
		act <= 1'b1;
		look(5);
		check({tx_grant, ant_to_ble, rx_enable}, 3'h1);
		step(1);
		act <= 1'b0;
		look(5);
		check(tx_grant, 1'b1);
		$display("test dual antenna done");
	endtask : t_dual
	task t_5g_off;
		step(1);
		cfg.band_5g <= 1'b1;
		cfg.shared_ant <= 1'b1;
		act <= 1'b1;
		look(6);
		check({tx_grant, ant_to_ble, status.ble_active}, 3'h5);
		step(1);
		cfg.band_5g <= 1'b0;
		sw_coex_clr <= 1'b1;
		step(1);
		sw_coex_clr <= 1'b0;
		look(6);
		check({status.coex_on, tx_grant, ant_to_ble}, 3'h2);
		step(1);
		act <= 1'b0;
		step(4);
		sw_coex_set <= 1'b1;
		step(1);
		sw_coex_set <= 1'b0;
		look(2);
		check({status.coex_on, tx_grant, ant_to_ble}, 3'h6);
		$display("test 5g and off done");
	endtask : t_5g_off
	task t_strap;
		step(1);
		cfg_strap <= 1'b1;
		rst <= 1'b1;
		step(2);
		rst <= 1'b0;
		look(1);
		check({status.coex_on, tx_grant}, 2'h0);
		look(5);
		check(status.coex_on, 1'b1);
		$display("test strap done");
	endtask : t_strap
	// main sequence, reset held 10 cycles
	initial begin
		step(10);
		rst <= 1'b0;
		t_pad();
		t_calfail();
		t_calok();
		t_block();
		t_dual();
		t_5g_off();
		t_strap();
		wrap_up();
	end
endmodule : test_ble_wlan_coex_arbiter
